// ### wwt_regs.vh
// register map, field positions, reset values and timing counts of the window watchdog
`ifndef WWT_REGS_VH
`define WWT_REGS_VH

// register byte offsets
`define WWT_OFS_RELOAD 8'h00
`define WWT_OFS_CTRL 8'h04
`define WWT_OFS_STATUS 8'h08
`define WWT_OFS_COUNT 8'h0C
`define WWT_OFS_MASK 8'h10

// reload key and reset values
`define WWT_RELOAD_KEY 32'h00005AA5
`define WWT_CTRL_RESET 32'h003F0800
`define WWT_MASK_RESET 2'h1
`define WWT_ZERO_WORD 32'h00000000

// control fields
`define WWT_CTRL_EN_BIT 0
`define WWT_CTRL_IE_BIT 1
`define WWT_CTRL_PSC_LSB 8
`define WWT_CTRL_PSC_MSB 11
`define WWT_CTRL_CMP_LSB 16
`define WWT_CTRL_CMP_MSB 21

// status fields
`define WWT_STAT_CMP_BIT 0
`define WWT_STAT_RST_BIT 1

// counter limits
`define WWT_CNT_TOP 6'h3F
`define WWT_CNT_ZERO 6'h00

// reload command takes effect after this many watchdog clock cycles
`define WWT_SYNC_CYCLES 2'h3

// prescale divisor minus one, per select code
`define WWT_PDIV_0 11'h000
`define WWT_PDIV_1 11'h001
`define WWT_PDIV_2 11'h003
`define WWT_PDIV_3 11'h007
`define WWT_PDIV_4 11'h00F
`define WWT_PDIV_5 11'h01F
`define WWT_PDIV_6 11'h03F
`define WWT_PDIV_7 11'h07F
`define WWT_PDIV_8 11'h0BF
`define WWT_PDIV_9 11'h0FF
`define WWT_PDIV_10 11'h17F
`define WWT_PDIV_11 11'h1FF
`define WWT_PDIV_12 11'h2FF
`define WWT_PDIV_13 11'h3FF
`define WWT_PDIV_14 11'h5FF
`define WWT_PDIV_15 11'h7FF

`endif

// ### wwt_prescaler.v
// selectable prescaler that turns watchdog clock ticks into counter steps
`timescale 1ns/1ps
`default_nettype none
`include "wwt_regs.vh"

module wwt_prescaler (
	input wire clk_in,
	input wire rst_n_in,
	input wire tick_in,
	input wire run_in,
	input wire [3:0] select_in,
	output reg step_out
);

	reg [10:0] pre_count;
	reg [10:0] last_value;

	// divisor lookup: 1,2,4..128,192,256,384,512,768,1024,1536,2048
	always @* begin
		case (select_in)
			4'h0: last_value = `WWT_PDIV_0;
			4'h1: last_value = `WWT_PDIV_1;
			4'h2: last_value = `WWT_PDIV_2;
			4'h3: last_value = `WWT_PDIV_3;
			4'h4: last_value = `WWT_PDIV_4;
			4'h5: last_value = `WWT_PDIV_5;
			4'h6: last_value = `WWT_PDIV_6;
			4'h7: last_value = `WWT_PDIV_7;
			4'h8: last_value = `WWT_PDIV_8;
			4'h9: last_value = `WWT_PDIV_9;
			4'hA: last_value = `WWT_PDIV_10;
			4'hB: last_value = `WWT_PDIV_11;
			4'hC: last_value = `WWT_PDIV_12;
			4'hD: last_value = `WWT_PDIV_13;
			4'hE: last_value = `WWT_PDIV_14;
			4'hF: last_value = `WWT_PDIV_15;
			default: last_value = `WWT_PDIV_0;
		endcase
	end

	// one step pulse per divisor watchdog ticks while running
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pre_count <= 11'h000;
			step_out <= 1'b0;
		end else begin
			step_out <= 1'b0;
			if (!run_in) begin
				pre_count <= 11'h000;
			end else if (tick_in) begin
				if (pre_count >= last_value) begin
					pre_count <= 11'h000;
					step_out <= 1'b1;
				end else begin
					pre_count <= pre_count + 11'h001;
				end
			end
		end
	end

endmodule
`default_nettype wire

// ### wwt_top.v
// window watchdog: down counter, window reload check, reset request, registers
//
// How it works
// [R1] enable starts unstoppable countdown from top
// [R2] count reaching zero requests system reset
// [R3] key reloads to top inside window only
// [R4] key above window requests reset at once
// [R5] control register takes one write only
// [R6] enable, prescale, compare frozen once enabled
// [R7] four-bit select picks one of sixteen divisors
// [R8] one decrement per prescale period
// [R9] count equal compare sets flag, write-one clears
// [R10] interrupt enable raises compare-match interrupt
// [R11] reset flag shows watchdog caused reset
// [R12] reload lands three watchdog clocks after write
// [R13] software keeps compare above small-divisor minimum
// [R14] power-down halts counting, no wake-up
// [R15] count register returns current six-bit count
// [R16] software reloads after flag, before zero
// [R17] non-key reload writes do nothing
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "wwt_regs.vh"

module wwt_top #(
	// system clocks per watchdog clock tick
	parameter WDCLK_DIV = 1
) (
	input wire CLK_IN,
	input wire RST_N_IN,
	input wire [7:0] ADDR_IN,
	input wire [31:0] WDATA_IN,
	input wire WR_IN,
	input wire RD_IN,
	output reg [31:0] RDATA_OUT,
	input wire PWR_DOWN_IN,
	input wire RST_CAUSE_WDT_IN,
	output reg IRQ_OUT,
	output reg SYS_RST_REQ_OUT
);

	localparam [15:0] WDCLK_LAST = WDCLK_DIV - 1;

	// watchdog clock tick divider
	reg [15:0] wdclk_count;
	reg wd_tick;

	// control register fields
	reg ctrl_locked;
	reg counter_enable;
	reg interrupt_enable;
	reg [3:0] prescale_select;
	reg [5:0] window_compare;

	// counter and reload synchroniser
	reg [5:0] count_value;
	reg reload_pend;
	reg [1:0] reload_stage;
	wire reload_apply;
	wire step;

	// status, mask and bookkeeping
	reg compare_match_flag;
	reg watchdog_reset_flag;
	reg [1:0] int_mask;
	reg match_seen;
	reg cause_taken;
	wire match_now;
	wire match_set;

	// bus decode
	wire wr_reload;
	wire wr_ctrl;
	wire wr_status;
	wire wr_mask;
	wire key_ok;
	wire in_window;
	wire reload_good;
	wire reload_early;
	wire hit_zero;
	wire next_irq;
	reg [31:0] next_rdata;

	assign wr_reload = WR_IN && (ADDR_IN == `WWT_OFS_RELOAD);
	assign wr_ctrl = WR_IN && (ADDR_IN == `WWT_OFS_CTRL);
	assign wr_status = WR_IN && (ADDR_IN == `WWT_OFS_STATUS);
	assign wr_mask = WR_IN && (ADDR_IN == `WWT_OFS_MASK);

	// key check and window comparison
	assign key_ok = (WDATA_IN == `WWT_RELOAD_KEY); // R17
	assign in_window = (count_value <= window_compare);
	assign reload_good = wr_reload && key_ok && counter_enable && in_window; // R3
	assign reload_early = wr_reload && key_ok && counter_enable && !in_window; // R4

	// watchdog clock divider, held still in power-down
	always @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			wdclk_count <= 16'h0000;
			wd_tick <= 1'b0;
		end else begin
			wd_tick <= 1'b0;
			if (PWR_DOWN_IN) begin
				wdclk_count <= wdclk_count; // R14
			end else if (wdclk_count >= WDCLK_LAST) begin
				wdclk_count <= 16'h0000;
				wd_tick <= 1'b1;
			end else begin
				wdclk_count <= wdclk_count + 16'h0001;
			end
		end
	end

	// control register: first write after reset wins, later ones dropped
	always @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ctrl_locked <= 1'b0;
			counter_enable <= 1'b0; // reset control word has enable clear
			interrupt_enable <= 1'b0; // and interrupt enable clear
			prescale_select <= 4'h8;
			window_compare <= `WWT_CNT_TOP;
		end else if (wr_ctrl && !ctrl_locked) begin
			ctrl_locked <= 1'b1; // R5
			counter_enable <= WDATA_IN[`WWT_CTRL_EN_BIT]; // R6
			interrupt_enable <= WDATA_IN[`WWT_CTRL_IE_BIT];
			prescale_select <= WDATA_IN[`WWT_CTRL_PSC_MSB:`WWT_CTRL_PSC_LSB]; // R6
			window_compare <= WDATA_IN[`WWT_CTRL_CMP_MSB:`WWT_CTRL_CMP_LSB]; // R6
		end
	end

	// prescaler: runs only while enabled and awake
	wwt_prescaler u_prescaler (
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.tick_in(wd_tick),
		.run_in(counter_enable && !PWR_DOWN_IN), // R14
		.select_in(prescale_select), // R7
		.step_out(step)
	);

	// reload command waits three watchdog clocks before landing
	always @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			reload_pend <= 1'b0;
			reload_stage <= 2'h0;
		end else if (reload_apply) begin
			reload_pend <= 1'b0;
			reload_stage <= 2'h0;
		end else if (reload_good && !reload_pend) begin
			reload_pend <= 1'b1;
			reload_stage <= 2'h0;
		end else if (reload_pend && wd_tick) begin
			reload_stage <= reload_stage + 2'h1; // R12
		end
	end

	assign reload_apply = reload_pend && wd_tick &&
		(reload_stage == `WWT_SYNC_CYCLES - 2'h1); // R12

	// down counter: reload beats a step in the same cycle
	always @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			count_value <= `WWT_CNT_TOP;
		end else if (reload_apply) begin
			count_value <= `WWT_CNT_TOP; // R3
		end else if (counter_enable && step && count_value != `WWT_CNT_ZERO) begin
			count_value <= count_value - 6'h01; // R1 R8
		end
	end

	// system reset request, held until the chip reset clears it
	assign hit_zero = counter_enable && (count_value == `WWT_CNT_ZERO);
	always @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			SYS_RST_REQ_OUT <= 1'b0;
		end else if (hit_zero) begin
			SYS_RST_REQ_OUT <= 1'b1; // R2
		end else if (reload_early) begin
			SYS_RST_REQ_OUT <= 1'b1; // R4
		end
	end

	// compare match detected on entry into the compare value
	assign match_now = counter_enable && (count_value == window_compare);
	assign match_set = match_now && !match_seen;
	always @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			match_seen <= 1'b0;
		end else begin
			match_seen <= match_now;
		end
	end

	// compare flag: hardware set wins over a write-one clear
	always @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			compare_match_flag <= 1'b0;
		end else if (match_set) begin
			compare_match_flag <= 1'b1; // R9
		end else if (wr_status && WDATA_IN[`WWT_STAT_CMP_BIT]) begin
			compare_match_flag <= 1'b0; // R9
		end
	end

	// reset cause caught once, at the first edge after release
	always @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			cause_taken <= 1'b0;
			watchdog_reset_flag <= 1'b0;
		end else if (!cause_taken) begin
			cause_taken <= 1'b1;
			watchdog_reset_flag <= RST_CAUSE_WDT_IN; // R11
		end else if (wr_status && WDATA_IN[`WWT_STAT_RST_BIT]) begin
			watchdog_reset_flag <= 1'b0; // R11
		end
	end

	// interrupt mask, same layout as status
	always @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			int_mask <= `WWT_MASK_RESET;
		end else if (wr_mask) begin
			int_mask <= WDATA_IN[1:0];
		end
	end

	// level interrupt from unmasked status bits
	assign next_irq = (compare_match_flag && interrupt_enable && int_mask[0]) ||
		(watchdog_reset_flag && int_mask[1]); // R10
	always @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			IRQ_OUT <= 1'b0;
		end else begin
			IRQ_OUT <= next_irq;
		end
	end

	// read mux; reload register and unmapped offsets read zero
	always @* begin
		next_rdata = `WWT_ZERO_WORD;
		case (ADDR_IN)
			`WWT_OFS_CTRL: begin
				next_rdata[`WWT_CTRL_EN_BIT] = counter_enable;
				next_rdata[`WWT_CTRL_IE_BIT] = interrupt_enable;
				next_rdata[`WWT_CTRL_PSC_MSB:`WWT_CTRL_PSC_LSB] = prescale_select;
				next_rdata[`WWT_CTRL_CMP_MSB:`WWT_CTRL_CMP_LSB] = window_compare;
			end
			`WWT_OFS_STATUS: begin
				next_rdata[`WWT_STAT_CMP_BIT] = compare_match_flag;
				next_rdata[`WWT_STAT_RST_BIT] = watchdog_reset_flag;
			end
			`WWT_OFS_COUNT: begin
				next_rdata[5:0] = count_value; // R15
			end
			`WWT_OFS_MASK: begin
				next_rdata[1:0] = int_mask;
			end
			default: begin
				next_rdata = `WWT_ZERO_WORD;
			end
		endcase
	end

	// read data stands only in the cycle after the strobe
	always @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			RDATA_OUT <= `WWT_ZERO_WORD;
		end else if (RD_IN) begin
			RDATA_OUT <= next_rdata;
		end else begin
			RDATA_OUT <= `WWT_ZERO_WORD;
		end
	end

endmodule
`default_nettype wire

// ### wwt_top_asserts.sv
// port checker of the window watchdog
`timescale 1ns/1ps
`default_nettype none
module wwt_top_asserts #(parameter WDCLK_DIV = 1) (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic [7:0] ADDR_IN,
	input wire logic [31:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	input wire logic [31:0] RDATA_OUT,
	input wire logic PWR_DOWN_IN,
	input wire logic RST_CAUSE_WDT_IN,
	input wire logic IRQ_OUT,
	input wire logic SYS_RST_REQ_OUT
);
	logic [31:0] ctl;
	logic locked;
	// shadow of the single control write
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ctl <= 32'h003F0800;
			locked <= 1'b0;
		end else if (WR_IN && ADDR_IN == 8'h04 && !locked) begin
			ctl <= WDATA_IN & 32'h003F0F03;
			locked <= 1'b1;
		end
	end
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	a_req_sticky: assert property (SYS_RST_REQ_OUT |=> SYS_RST_REQ_OUT)
		else $error("reset request dropped");
	a_req_enabled: assert property (!ctl[0] |-> !SYS_RST_REQ_OUT)
		else $error("reset request while disabled");
	a_ctl_once: assert property (RD_IN && ADDR_IN == 8'h04 |=> RDATA_OUT == ctl)
		else $error("control changed after first write");
	a_rd_idle: assert property (!RD_IN |=> RDATA_OUT == 32'h00000000)
		else $error("read data outside read cycle");
	a_rd_count: assert property (RD_IN && ADDR_IN == 8'h0C |=> RDATA_OUT[31:6] == 26'h0)
		else $error("count upper bits set");
	a_rd_status: assert property (RD_IN && ADDR_IN == 8'h08 |=> RDATA_OUT[31:2] == 30'h0)
		else $error("status upper bits set");
	a_rd_reload: assert property (RD_IN && ADDR_IN == 8'h00 |=> RDATA_OUT == 32'h0)
		else $error("reload register readable");
	a_rd_unmap: assert property (RD_IN && ADDR_IN > 8'h10 |=> RDATA_OUT == 32'h0)
		else $error("unmapped read not zero");
endmodule
bind wwt_top wwt_top_asserts #(.WDCLK_DIV(WDCLK_DIV)) wwt_top_asserts_inst (.CLK_IN(CLK_IN),
	.RST_N_IN(RST_N_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN),
	.RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .PWR_DOWN_IN(PWR_DOWN_IN),
	.RST_CAUSE_WDT_IN(RST_CAUSE_WDT_IN), .IRQ_OUT(IRQ_OUT), .SYS_RST_REQ_OUT(SYS_RST_REQ_OUT));
`default_nettype wire

// ### window_watchdog_timer_tb.sv
// self-checking bench of the window watchdog
`timescale 1ns/1ps
`default_nettype none
module window_watchdog_timer_tb;
	logic CLK_IN, RST_N_IN, WR_IN, RD_IN, PWR_DOWN_IN, RST_CAUSE_WDT_IN;
	logic [7:0] ADDR_IN;
	logic [31:0] WDATA_IN, d;
	wire [31:0] RDATA_OUT;
	wire IRQ_OUT, SYS_RST_REQ_OUT;
	int error_cnt = 0, num_checks = 0, cyc = 0, t0;
	wwt_top #(.WDCLK_DIV(1)) wwt_top_inst (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
		.ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
		.RDATA_OUT(RDATA_OUT), .PWR_DOWN_IN(PWR_DOWN_IN), .RST_CAUSE_WDT_IN(RST_CAUSE_WDT_IN),
		.IRQ_OUT(IRQ_OUT), .SYS_RST_REQ_OUT(SYS_RST_REQ_OUT));
	// 25 MHz clock
	initial begin
		CLK_IN = 1'b0;
		forever #20 CLK_IN = ~CLK_IN;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// hang guard
	always @(posedge CLK_IN) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge CLK_IN);
		WR_IN <= 1'b1;
		ADDR_IN <= a;
		WDATA_IN <= v;
		@(posedge CLK_IN);
		WR_IN <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge CLK_IN);
		RD_IN <= 1'b1;
		ADDR_IN <= a;
		@(posedge CLK_IN);
		RD_IN <= 1'b0;
		@(negedge CLK_IN);
		d = RDATA_OUT;
	endtask
	task automatic do_reset(input logic cause);
		@(posedge CLK_IN);
		RST_N_IN <= 1'b0;
		RST_CAUSE_WDT_IN <= cause;
		repeat (2) @(posedge CLK_IN);
		RST_N_IN <= 1'b1;
	endtask
	task automatic wait_req(input int lim);
		t0 = cyc;
		while (SYS_RST_REQ_OUT !== 1'b1 && cyc - t0 < lim) @(posedge CLK_IN);
	endtask
	task automatic t_regs;
		rd(8'h04);
		chk(d, 32'h003F0800);
		rd(8'h0C);
		chk(d, 32'h0000003F);
		rd(8'h00);
		chk(d, 32'h00000000);
		rd(8'h14);
		chk(d, 32'h00000000);
		$display("t_regs done");
	endtask
	task automatic t_expire(input logic [3:0] code, input int div);
		do_reset(1'b0);
		wr(8'h04, {12'h003, 4'hF, 4'h0, code, 8'h01});
		wr(8'h04, 32'h00000000);
		rd(8'h04);
		chk(d, {12'h003, 4'hF, 4'h0, code, 8'h01});
		wait_req(div * 64 + 40);
		chk({31'h0, cyc - t0 >= div * 63 - 12 && cyc - t0 <= div * 64}, 32'h1);
		$display("t_expire code %0d done", code);
	endtask
	task automatic t_window;
		do_reset(1'b0);
		wr(8'h04, 32'h00200003);
		wr(8'h00, 32'h00001234);
		chk({31'h0, SYS_RST_REQ_OUT}, 32'h0);
		t0 = cyc;
		while (IRQ_OUT !== 1'b1 && cyc - t0 < 100) @(posedge CLK_IN);
		rd(8'h08);
		chk(d, 32'h00000001);
		wr(8'h00, 32'h00005AA5);
		rd(8'h0C);
		chk({31'h0, d <= 32'h20}, 32'h1);
		rd(8'h0C);
		chk({31'h0, d >= 32'h3E}, 32'h1);
		wr(8'h10, 32'h00000000);
		@(posedge CLK_IN);
		@(negedge CLK_IN);
		chk({31'h0, IRQ_OUT}, 32'h0);
		wr(8'h10, 32'h00000001);
		@(posedge CLK_IN);
		@(negedge CLK_IN);
		chk({31'h0, IRQ_OUT}, 32'h1);
		wr(8'h08, 32'h00000001);
		@(posedge CLK_IN);
		@(negedge CLK_IN);
		chk({31'h0, IRQ_OUT}, 32'h0);
		chk({31'h0, SYS_RST_REQ_OUT}, 32'h0);
		wr(8'h00, 32'h00005AA5);
		@(negedge CLK_IN);
		chk({31'h0, SYS_RST_REQ_OUT}, 32'h1);
		$display("t_window done");
	endtask
	task automatic t_flag;
		do_reset(1'b1);
		rd(8'h08);
		chk(d, 32'h00000002);
		wr(8'h10, 32'h00000002);
		@(posedge CLK_IN);
		@(negedge CLK_IN);
		chk({31'h0, IRQ_OUT}, 32'h1);
		wr(8'h08, 32'h00000002);
		rd(8'h08);
		chk(d, 32'h00000000);
		chk({31'h0, IRQ_OUT}, 32'h0);
		$display("t_flag done");
	endtask
	task automatic t_pwrdn;
		do_reset(1'b0);
		PWR_DOWN_IN <= 1'b1;
		wr(8'h04, 32'h003F0001);
		repeat (100) @(posedge CLK_IN);
		rd(8'h0C);
		chk(d, 32'h0000003F);
		PWR_DOWN_IN <= 1'b0;
		wait_req(120);
		chk({31'h0, cyc - t0 >= 58 && cyc - t0 <= 70}, 32'h1);
		$display("t_pwrdn done");
	endtask
	// main sequence
	initial begin
		{WR_IN, RD_IN, PWR_DOWN_IN, ADDR_IN, WDATA_IN} = '0;
		RST_N_IN = 1'b0;
		RST_CAUSE_WDT_IN = 1'b0;
		do_reset(1'b0);
		t_regs();
		t_expire(4'h0, 1);
		t_expire(4'h3, 8);
		t_expire(4'h8, 192);
		t_window();
		t_flag();
		t_pwrdn();
		tally_and_finish();
	end
endmodule
`default_nettype wire
